// *** hdl/clock_source_ctrl.sv ***
// Purpose: System clock source select, internal oscillator tune, status
// Assumes: Source ticks arrive as one-cycle enables on the core clock
// Notes: Clock gating is expressed as enables, never as gated clocks
//
// Register access over Wishbone and the address map were left to the implementer.
`include "clk_ctrl_params.svh"
`timescale 1ns/1ps
module clock_source_ctrl #(
	parameter int FAST_SETTLE_CYCLES = `FAST_SETTLE_US * `CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire clk_ctrl_pkg::wb_req_type wb_req_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] cfg_primary_mode_i,
	input wire logic pri_tick_i,
	input wire logic sec_tick_i,
	input wire logic ost_expired_i,
	input wire logic two_speed_i,
	input wire logic sleep_i,
	input wire logic wake_i,
	output logic [3:0] primary_mode_o,
	output logic sys_clk_en_o,
	output logic core_clk_en_o,
	output logic slow_rc_tick_o,
	output logic pm_active_o,
	output clk_ctrl_pkg::clk_src_type active_src_o
);

	// Bus decode
	logic bus_req;
	logic wr_stb;
	logic trim_wr;
	logic [31:0] next_rdata;
	// Software visible state
	logic [5:0] trim;
	logic idle_on_sleep;
	logic [2:0] internal_freq_select;
	logic [1:0] clock_source_select;
	logic secondary_osc_enable;
	clk_ctrl_pkg::osc_status_type status;
	clk_ctrl_pkg::osc_status_type next_status;
	// Trim settling
	logic [5:0] fast_trim;
	logic [5:0] slow_trim;
	logic fast_pend;
	logic slow_pend;
	logic [`FAST_CNT_W-1:0] fast_cnt;
	logic [3:0] slow_cnt;
	logic signed [23:0] fast_off;
	logic signed [23:0] slow_off;
	logic [23:0] fast_inc;
	logic [23:0] slow_inc;
	// Oscillator ticks
	logic fast_tick;
	logic slow_tick;
	logic [5:0] ps_tick;
	logic int_tick;
	// Switch sequencer
	clk_ctrl_pkg::sw_state_type state;
	clk_ctrl_pkg::clk_src_type active;
	clk_ctrl_pkg::clk_src_type target;
	clk_ctrl_pkg::clk_src_type next_target;
	logic pm;
	logic [3:0] pause_cnt;
	logic deep_sleep;
	logic act_tick;
	logic tgt_tick;
	logic por_pend;

	// Single-cycle classic slave; ack is held off after each answer
	assign bus_req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	assign wr_stb = bus_req && wb_req_i.we && wb_req_i.sel[0];
	assign trim_wr = wr_stb && (wb_req_i.adr == `ADR_TRIM);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end
	// Read mux; unmapped addresses answer with zero
	always_comb begin
		next_rdata = 32'h00000000;
		unique case (wb_req_i.adr)
			`ADR_TRIM: next_rdata = {26'h0000000, trim};
			`ADR_OSC: next_rdata = {24'h000000, idle_on_sleep,
				internal_freq_select, status.primary_startup_done,
				status.internal_freq_stable, clock_source_select};
			`ADR_T1: next_rdata = {24'h000000, 1'b0,
				status.secondary_clock_active, 2'b00,
				secondary_osc_enable, 3'b000};
			`ADR_PM: next_rdata = {26'h0000000, state, pm, active};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_req && !wb_req_i.we) begin
			wb_dat_o <= next_rdata;
		end else begin
			wb_dat_o <= 32'h00000000;
		end
	end

	// Trim register; only the six code bits are stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim <= `TRIM_RST;
		end else if (trim_wr) begin
			trim <= wb_req_i.dat[5:0];
		end
	end
	// Oscillator control register; reset clears the select bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_on_sleep <= 1'b0;
			internal_freq_select <= `IFS_RST;
			clock_source_select <= `SCS_RST;
		end else if (wr_stb && (wb_req_i.adr == `ADR_OSC)) begin
			idle_on_sleep <= wb_req_i.dat[`OSC_IDLE_BIT];
			internal_freq_select <= wb_req_i.dat[`OSC_IFS_LSB +: 3];
			clock_source_select <= wb_req_i.dat[1:0];
		end
	end
	// Timer1 oscillator enable; other Timer1 bits live in Timer1 itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			secondary_osc_enable <= 1'b0;
		end else if (wr_stb && (wb_req_i.adr == `ADR_T1)) begin
			secondary_osc_enable <= wb_req_i.dat[`T1_EN_BIT];
		end
	end

	// Fast oscillator follows a trim write after the settle time
	// Limitation: counter width bounds the settle parameter at 2^18
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_trim <= `TRIM_CENTRE;
			fast_pend <= 1'b0;
			fast_cnt <= '0;
		end else if (trim_wr) begin
			fast_pend <= 1'b1;
			fast_cnt <= `FAST_CNT_W'(FAST_SETTLE_CYCLES - 1);
		end else if (fast_pend) begin
			if (fast_cnt == '0) begin
				fast_trim <= trim;
				fast_pend <= 1'b0;
			end else begin
				fast_cnt <= fast_cnt - 1'b1;
			end
		end
	end
	// Slow RC follows on its eighth own period after the write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_trim <= `TRIM_CENTRE;
			slow_pend <= 1'b0;
			slow_cnt <= 4'h0;
		end else if (trim_wr) begin
			slow_pend <= 1'b1;
			slow_cnt <= 4'h0;
		end else if (slow_pend && slow_tick) begin
			if (slow_cnt == `SLOW_SETTLE_TICKS - 4'h1) begin
				slow_trim <= trim;
				slow_pend <= 1'b0;
			end else begin
				slow_cnt <= slow_cnt + 4'h1;
			end
		end
	end

	// Signed trim scales a fixed step, so every code moves equally
	assign fast_off = $signed(fast_trim) * `FAST_INC_STEP;
	assign slow_off = $signed(slow_trim) * `SLOW_INC_STEP;
	assign fast_inc = `FAST_INC_BASE + fast_off;
	assign slow_inc = `SLOW_INC_BASE + slow_off;

	// Internal oscillators run free; no flag reports the retune
	nco_tick u_fast_nco (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.inc_i(fast_inc),
		.tick_o(fast_tick)
	);
	nco_tick u_slow_nco (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.inc_i(slow_inc),
		.tick_o(slow_tick)
	);
	postscaler u_postscaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(fast_tick),
		.tick_o(ps_tick)
	);

	// Frequency select feeds straight through, no resync delay
	always_comb begin
		int_tick = 1'b0;
		if (internal_freq_select == `IFS_FAST) begin
			int_tick = fast_tick;
		end else if (internal_freq_select == `IFS_SLOW) begin
			int_tick = slow_tick;
		end else begin
			int_tick = ps_tick[`IFS_TAP_TOP - internal_freq_select];
		end
	end

	// Source decode; Timer1 is refused while its oscillator is off
	always_comb begin
		next_target = clk_ctrl_pkg::SRC_PRIMARY;
		if (clock_source_select[1]) begin
			next_target = clk_ctrl_pkg::SRC_INTERNAL;
		end else if (clock_source_select[0] && secondary_osc_enable) begin
			next_target = clk_ctrl_pkg::SRC_SECONDARY;
		end
	end

	// One-hot source masks the three ticks; serves live and target source
	assign act_tick = |(active & {int_tick, sec_tick_i, pri_tick_i});
	assign tgt_tick = |(target & {int_tick, sec_tick_i, pri_tick_i});

	// Switch sequencer: select is read only at sleep, wake goes primary
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= clk_ctrl_pkg::ST_STEADY;
			active <= clk_ctrl_pkg::SRC_PRIMARY;
			target <= clk_ctrl_pkg::SRC_PRIMARY;
			pm <= 1'b0;
			pause_cnt <= 4'h0;
		end else begin
			unique case (state)
				clk_ctrl_pkg::ST_STEADY: begin
					pause_cnt <= 4'h0;
					if (sleep_i && !pm) begin
						pm <= 1'b1;
						target <= next_target;
						if (next_target != active) begin
							state <= clk_ctrl_pkg::ST_SWITCH;
						end
					end else if (wake_i && pm) begin
						pm <= 1'b0;
						target <= clk_ctrl_pkg::SRC_PRIMARY;
						if (active != clk_ctrl_pkg::SRC_PRIMARY) begin
							state <= clk_ctrl_pkg::ST_SWITCH;
						end
					end
				end
				clk_ctrl_pkg::ST_SWITCH: begin
					// Eight new-source periods pass with no clock
					if (tgt_tick) begin
						if (pause_cnt == `SWITCH_PAUSE_TICKS - 4'h1) begin
							active <= target;
							state <= clk_ctrl_pkg::ST_STEADY;
						end else begin
							pause_cnt <= pause_cnt + 4'h1;
						end
					end
				end
			endcase
		end
	end

	// Sleep proper: primary with idle clear stops every system clock
	assign deep_sleep = pm && !idle_on_sleep
		&& (active == clk_ctrl_pkg::SRC_PRIMARY);

	// Clock enables; the core is held off in idle and in sleep
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_clk_en_o <= 1'b0;
			core_clk_en_o <= 1'b0;
		end else begin
			sys_clk_en_o <= (state == clk_ctrl_pkg::ST_STEADY)
				&& act_tick && !deep_sleep;
			core_clk_en_o <= (state == clk_ctrl_pkg::ST_STEADY)
				&& act_tick && !deep_sleep
				&& !(pm && idle_on_sleep);
		end
	end

	// Status flags; the active source is one-hot so one flag at most
	always_comb begin
		next_status.primary_startup_done =
			(active == clk_ctrl_pkg::SRC_PRIMARY)
			&& ost_expired_i;
		next_status.internal_freq_stable =
			(internal_freq_select != `IFS_SLOW)
			&& (state == clk_ctrl_pkg::ST_STEADY)
			&& ((active == clk_ctrl_pkg::SRC_INTERNAL)
			|| ((active == clk_ctrl_pkg::SRC_PRIMARY)
			&& two_speed_i && !ost_expired_i));
		next_status.secondary_clock_active =
			(active == clk_ctrl_pkg::SRC_SECONDARY)
			&& (state == clk_ctrl_pkg::ST_STEADY);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// Primary mode is caught once, on the first edge after reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			por_pend <= 1'b1;
			primary_mode_o <= 4'h0;
		end else if (por_pend) begin
			por_pend <= 1'b0;
			primary_mode_o <= cfg_primary_mode_i;
		end
	end

	// Slow RC tick runs in every mode for watchdog and monitor
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_rc_tick_o <= 1'b0;
			pm_active_o <= 1'b0;
			active_src_o <= clk_ctrl_pkg::SRC_PRIMARY;
		end else begin
			slow_rc_tick_o <= slow_tick;
			pm_active_o <= pm;
			active_src_o <= active;
		end
	end

endmodule : clock_source_ctrl

// *** hdl/clk_ctrl_params.svh ***
// Purpose: Constants for the system clock source select and tune block
// Assumes: 250 MHz core clock, registers in byte lane 0 of a 32-bit bus
// Notes: Offsets, fields, reset values and timing counts live here
`ifndef CLK_CTRL_PARAMS_SVH
`define CLK_CTRL_PARAMS_SVH

// Register byte addresses
`define ADR_TRIM 8'h00
`define ADR_OSC 8'h04
`define ADR_T1 8'h08
`define ADR_PM 8'h0c

// Field positions
`define OSC_IDLE_BIT 7
`define OSC_IFS_LSB 4
`define OSC_PRIMARY_STARTUP_DONE_BIT 3
`define OSC_INTERNAL_FREQ_STABLE_BIT 2
`define T1_RUN_BIT 6
`define T1_EN_BIT 3

// Reset values
`define TRIM_RST 6'h00
`define IFS_RST 3'h0
`define SCS_RST 2'h0

// Trim codes, two's complement
`define TRIM_MAX 6'h1f
`define TRIM_CENTRE 6'h00
`define TRIM_MIN 6'h20

// Frequency select codes that bypass the postscaler, and the code of the top postscaler tap
`define IFS_FAST 3'h7
`define IFS_SLOW 3'h0
`define IFS_TAP_TOP 3'h6

// Phase increments at 250 MHz with a 24-bit accumulator
`define FAST_INC_BASE 24'h083127
`define FAST_INC_STEP 24'sh000a7c
`define SLOW_INC_BASE 24'h000831
`define SLOW_INC_STEP 24'sh00000a

// Timing
`define CLK_MHZ 250
`define FAST_SETTLE_US 1000
`define FAST_CNT_W 18
`define SLOW_SETTLE_TICKS 4'h8
`define SWITCH_PAUSE_TICKS 4'h8

`endif

// *** hdl/clk_ctrl_pkg.sv ***
// Purpose: Types shared by the clock control block and its bench
// Assumes: Constants come from clk_ctrl_params.svh
// Notes: Enumerations are one-hot
package clk_ctrl_pkg;

	// Three clock source classes
	typedef enum logic [2:0] {
		SRC_PRIMARY = 3'b001,
		SRC_SECONDARY = 3'b010,
		SRC_INTERNAL = 3'b100
	} clk_src_type;

	// Source switch sequencer
	typedef enum logic [1:0] {
		ST_STEADY = 2'b01,
		ST_SWITCH = 2'b10
	} sw_state_type;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_type;

	// Clock source status flags
	typedef struct packed {
		logic primary_startup_done;
		logic internal_freq_stable;
		logic secondary_clock_active;
	} osc_status_type;

endpackage : clk_ctrl_pkg

// *** hdl/nco_tick.sv ***
// Purpose: Numerically controlled oscillator giving one-cycle ticks
// Assumes: Increment is a fraction of 2^24 of the core clock
// Notes: Tick rate is linear in the increment
`timescale 1ns/1ps
module nco_tick (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [23:0] inc_i,
	output logic tick_o
);

	logic [23:0] acc;
	logic [24:0] next_acc;

	// Carry out of the accumulator marks one oscillator period
	assign next_acc = {1'b0, acc} + {1'b0, inc_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= 24'h000000;
			tick_o <= 1'b0;
		end else begin
			acc <= next_acc[23:0];
			tick_o <= next_acc[24];
		end
	end

endmodule : nco_tick

// *** hdl/postscaler.sv ***
// Purpose: Binary postscaler chain for the fast internal oscillator
// Assumes: tick_i is a one-cycle enable at the fast rate
// Notes: tick_o[k] runs at the input rate over 2^(k+1), one cycle late
`timescale 1ns/1ps
module postscaler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	output logic [5:0] tick_o
);

	logic [5:0] phase;
	logic [5:0] carry;

	assign carry[0] = tick_i;

	// One toggle stage per halving
	for (genvar k = 0; k < 6; k++) begin : g_stage
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				phase[k] <= 1'b0;
				tick_o[k] <= 1'b0;
			end else begin
				if (carry[k]) begin
					phase[k] <= ~phase[k];
				end
				tick_o[k] <= carry[k] && phase[k];
			end
		end
		if (k < 5) begin : g_carry
			assign carry[k + 1] = carry[k] && phase[k];
		end
	end

endmodule : postscaler

// *** dv/clk_ctrl_properties.sv ***
// Purpose: Port-level properties of the clock source controller
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound onto every controller instance below the module
`timescale 1ns/1ps
`include "clk_ctrl_params.svh"
module clk_ctrl_properties #(
	parameter int FAST_SETTLE_CYCLES = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire clk_ctrl_pkg::wb_req_type wb_req_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic pri_tick_i,
	input wire logic sec_tick_i,
	input wire logic sleep_i,
	input wire logic wake_i,
	input wire logic [3:0] primary_mode_o,
	input wire logic sys_clk_en_o,
	input wire logic core_clk_en_o,
	input wire logic pm_active_o,
	input wire clk_ctrl_pkg::clk_src_type active_src_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] quiet;
	logic ext_tick;
	logic [1:0] age;
	// Idle cycles since last enable; saturates so long waits stay legal
	always_ff @(posedge clk_i) begin
		if (rst_i || sys_clk_en_o)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	// Tick of the live external source, one cycle back
	always_ff @(posedge clk_i) begin
		ext_tick <= (active_src_o == clk_ctrl_pkg::SRC_PRIMARY && pri_tick_i)
			|| (active_src_o == clk_ctrl_pkg::SRC_SECONDARY && sec_tick_i);
	end
	// Edges since reset release, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end
	sequence s_req_taken;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	endsequence
	a_ack_follows_req: assert property (s_req_taken |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack cycle");
	a_dat_upper_zero: assert property (
		wb_dat_o[31:8] == 24'h0 && (wb_dat_o[7:6] == 2'h0
		|| $past(wb_req_i.adr) != `ADR_TRIM))
		else $error("unimplemented read data bits not zero");
	a_src_one_hot: assert property ($onehot(active_src_o))
		else $error("live source not one of three");
	a_pm_entry: assert property ($rose(pm_active_o) |-> $past(sleep_i, 2))
		else $error("low power entered without sleep");
	a_pm_exit: assert property ($fell(pm_active_o) |-> $past(wake_i, 2))
		else $error("low power left without wake");
	a_switch_pause: assert property (
		$changed(active_src_o) |-> quiet >= 4'h8)
		else $error("source switched without pause");
	a_core_needs_sys: assert property (core_clk_en_o |-> sys_clk_en_o)
		else $error("core enabled without system enable");
	a_ext_tick_src: assert property (
		sys_clk_en_o && !active_src_o[2] |-> ext_tick)
		else $error("enable without live source tick");
	a_mode_frozen: assert property (
		age == 2'h3 |-> $stable(primary_mode_o))
		else $error("primary mode changed after latch");
endmodule : clk_ctrl_properties

bind clock_source_ctrl clk_ctrl_properties #(
	.FAST_SETTLE_CYCLES(FAST_SETTLE_CYCLES)
) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .pri_tick_i(pri_tick_i), .sec_tick_i(sec_tick_i),
	.sleep_i(sleep_i), .wake_i(wake_i), .primary_mode_o(primary_mode_o),
	.sys_clk_en_o(sys_clk_en_o), .core_clk_en_o(core_clk_en_o),
	.pm_active_o(pm_active_o), .active_src_o(active_src_o)
);

// *** dv/core_model.sv ***
// Purpose: Processor core and oscillator pins facing the controller
// Assumes: Requests arrive as one-cycle levels from the bench
// Notes: Oscillators run free, as real crystals do
`timescale 1ns/1ps
module core_model #(
	parameter int PRI_DIV = 3,
	parameter int SEC_DIV = 7
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sleep_req_i,
	input wire logic wake_req_i,
	output logic pri_tick_o,
	output logic sec_tick_o,
	output logic sleep_o,
	output logic wake_o
);
	int pri_cnt;
	int sec_cnt;
	// Timer1 kept running so a sleep onto it never waits on start-up
	always_ff @(posedge clk_i) begin
		pri_cnt <= (rst_i || pri_cnt >= PRI_DIV - 1) ? 0 : pri_cnt + 1;
		sec_cnt <= (rst_i || sec_cnt >= SEC_DIV - 1) ? 0 : sec_cnt + 1;
		pri_tick_o <= !rst_i && pri_cnt == 0;
		sec_tick_o <= !rst_i && sec_cnt == 0;
	end
	// Sleep instruction and wake event as single-cycle pulses
	always_ff @(posedge clk_i) begin
		sleep_o <= sleep_req_i;
		wake_o <= wake_req_i;
	end
endmodule : core_model

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the clock source controller
// Assumes: Partner core model supplies ticks and sleep/wake pulses
// Notes: Short fast-settle count keeps the run brief
`timescale 1ns/1ps
`include "clk_ctrl_params.svh"
module tb_top;
	logic clk_i, rst_i, sleep_req, wake_req, ack, pri_t, sec_t;
	logic sleep_p, wake_p, sys_en, core_en, slow_t, pm, ost_x, two_x;
	logic [31:0] rdat, q, d;
	logic [3:0] cfg, pmode;
	logic [5:0] tbl [3] = '{6'h1f, 6'h00, 6'h20};
	clk_ctrl_pkg::wb_req_type req;
	clk_ctrl_pkg::clk_src_type src;
	int err_total, check_count, c7, c6, cmax, cmin, m, cyc_n, slow_n;
	int seed = 59;
	// Free-running 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	clock_source_ctrl #(.FAST_SETTLE_CYCLES(20)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack),
		.wb_dat_o(rdat), .cfg_primary_mode_i(cfg), .pri_tick_i(pri_t),
		.sec_tick_i(sec_t), .ost_expired_i(ost_x), .two_speed_i(two_x),
		.sleep_i(sleep_p), .wake_i(wake_p), .primary_mode_o(pmode),
		.sys_clk_en_o(sys_en), .core_clk_en_o(core_en),
		.slow_rc_tick_o(slow_t), .pm_active_o(pm), .active_src_o(src));
	core_model #(.PRI_DIV(3), .SEC_DIV(7)) u_core (
		.clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req),
		.wake_req_i(wake_req), .pri_tick_o(pri_t), .sec_tick_o(sec_t),
		.sleep_o(sleep_p), .wake_o(wake_p));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Classic single cycle, held until ack is sampled
	task automatic bus(input logic we, input logic [7:0] a,
			input logic [31:0] dw, input logic [3:0] s);
		req <= '{1'b1, 1'b1, we, a, s, dw};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		req <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] dw);
		bus(1'b1, a, dw, 4'hf);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask : rd
	// One-cycle sleep or wake request to the core model
	task automatic pm_req(input logic w);
		if (w)
			wake_req <= 1'b1;
		else
			sleep_req <= 1'b1;
		@(posedge clk_i);
		sleep_req <= 1'b0;
		wake_req <= 1'b0;
		@(posedge clk_i);
	endtask : pm_req
	task automatic wait_src(input clk_ctrl_pkg::clk_src_type e);
		int i;
		i = 0;
		while (src !== e && i < 3000) begin
			@(posedge clk_i);
			i++;
		end
		check({29'h0, src}, {29'h0, e});
	endtask : wait_src
	// Count system and core enables over a fixed window
	task automatic meas(output int n, output int k);
		n = 0;
		k = 0;
		repeat (4000) begin
			@(posedge clk_i);
			if (sys_en === 1'b1)
				n++;
			if (core_en === 1'b1)
				k++;
		end
	endtask : meas
	function automatic logic [31:0] osc_exp(input logic [7:0] c,
			input logic [1:0] st);
		return {24'h0, c[7:4], st, c[1:0]};
	endfunction : osc_exp
	// Slow RC ticks expected at centre trim; later retunes never settle
	function automatic int slow_exp(input int n);
		return int'((longint'(n) * `SLOW_INC_BASE) >> 24);
	endfunction : slow_exp
	// Slow RC ticks and live cycles since the first reset release
	always @(posedge clk_i) begin
		if (rst_i === 1'b0) begin
			cyc_n++;
			if (slow_t === 1'b1)
				slow_n++;
		end
	end
	task automatic end_of_test;
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		end_of_test;
	end
	initial begin
		req = '0;
		sleep_req = 1'b0;
		wake_req = 1'b0;
		ost_x = 1'b1;
		two_x = 1'b0;
		rst_i = 1'b1;
		cfg = 4'($random(seed));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check({28'h0, pmode}, {28'h0, cfg});
		rd(`ADR_OSC);
		check(q, osc_exp(8'h00, 2'b10));
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			if (i < 3)
				d[5:0] = tbl[i];
			wr(`ADR_TRIM, d);
			rd(`ADR_TRIM);
			check(q, {26'h0, d[5:0]});
		end
		bus(1'b1, `ADR_TRIM, 32'h3f, 4'he);
		rd(`ADR_TRIM);
		check(q, {26'h0, d[5:0]});
		wr(8'h10, 32'hff);
		rd(8'h10);
		check(q, 32'h0);
		wr(`ADR_TRIM, 32'h0);
		wr(`ADR_T1, 32'h0);
		wr(`ADR_OSC, 32'h72);
		check({29'h0, src}, {29'h0, clk_ctrl_pkg::SRC_PRIMARY});
		pm_req(1'b0);
		wait_src(clk_ctrl_pkg::SRC_INTERNAL);
		check({31'h0, pm}, 32'h1);
		rd(`ADR_OSC);
		check(q, osc_exp(8'h72, 2'b01));
		meas(c7, m);
		wr(`ADR_OSC, 32'h62);
		meas(c6, m);
		check({31'h0, c7 > c6 + c6 / 2 && c6 > 0}, 32'h1);
		wr(`ADR_OSC, 32'h72);
		wr(`ADR_TRIM, 32'h1f);
		repeat (50) @(posedge clk_i);
		meas(cmax, m);
		wr(`ADR_TRIM, 32'h20);
		repeat (50) @(posedge clk_i);
		meas(cmin, m);
		check({31'h0, cmax > c7 && c7 > cmin}, 32'h1);
		m = (cmax - c7) - (c7 - cmin);
		check({31'h0, m <= 3 && m >= -3}, 32'h1);
		wr(`ADR_TRIM, 32'h0);
		pm_req(1'b1);
		wait_src(clk_ctrl_pkg::SRC_PRIMARY);
		wr(`ADR_OSC, 32'h01);
		pm_req(1'b0);
		repeat (100) @(posedge clk_i);
		check({29'h0, src}, {29'h0, clk_ctrl_pkg::SRC_PRIMARY});
		check({31'h0, pm}, 32'h1);
		pm_req(1'b1);
		repeat (40) @(posedge clk_i);
		wr(`ADR_T1, 32'h08);
		pm_req(1'b0);
		wait_src(clk_ctrl_pkg::SRC_SECONDARY);
		rd(`ADR_T1);
		check(q, 32'h48);
		rd(`ADR_OSC);
		check(q, osc_exp(8'h01, 2'b00));
		pm_req(1'b1);
		wait_src(clk_ctrl_pkg::SRC_PRIMARY);
		wr(`ADR_OSC, 32'hf2);
		pm_req(1'b0);
		wait_src(clk_ctrl_pkg::SRC_INTERNAL);
		meas(c7, m);
		check(32'(m), 32'h0);
		check({31'h0, c7 > 0}, 32'h1);
		pm_req(1'b1);
		wait_src(clk_ctrl_pkg::SRC_PRIMARY);
		meas(c7, m);
		check({31'h0, m > 0}, 32'h1);
		check({31'h0, pm}, 32'h0);
		check({31'h0, slow_n >= slow_exp(cyc_n) - 1
			&& slow_n <= slow_exp(cyc_n) + 1}, 32'h1);
		// Two-speed start-up on primary, then start-up timer expiry
		ost_x <= 1'b0;
		two_x <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(`ADR_OSC);
		check(q, osc_exp(8'hf2, 2'b01));
		ost_x <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(`ADR_OSC);
		check(q, osc_exp(8'hf2, 2'b10));
		two_x <= 1'b0;
		// Configuration change is ignored until the next reset
		cfg <= ~cfg;
		repeat (2) @(posedge clk_i);
		check({28'h0, pmode}, {28'h0, ~cfg});
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check({28'h0, pmode}, {28'h0, cfg});
		rd(`ADR_OSC);
		check(q, osc_exp(8'h00, 2'b10));
		check({29'h0, src}, {29'h0, clk_ctrl_pkg::SRC_PRIMARY});
		end_of_test;
	end
endmodule : tb_top
